// *** rtl/pcxcfg_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "pcxcfg_defs.svh"
module pcxcfg_regs #(
    // Arbitrary neutral identifier defaults.
    parameter logic [15:0] MAKER_ID_DEFAULT = 16'h1234,
    parameter logic [15:0] PART_ID_DEFAULT = 16'h5678
) (
    // Clock, reset, enable
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // Configuration access from the upstream link
    input wire logic cfg_rd_i,
    input wire logic cfg_wr_i,
    input wire pcxcfg_pkg::pcxcfg_addr_t cfg_addr_i,
    input wire pcxcfg_pkg::pcxcfg_word_t cfg_wdata_i,
    input wire logic [3:0] cfg_be_i,
    output logic cfg_rvalid_o,
    output pcxcfg_pkg::pcxcfg_word_t cfg_rdata_o,
    // Identifier override from the SMBus slave or EEPROM autoload
    input wire logic id_load_i,
    input wire logic [15:0] id_maker_i,
    input wire logic [15:0] id_part_i,
    // Error events and logged header
    input wire logic [31:0] ue_event_i,
    input wire logic [31:0] ce_event_i,
    input wire logic hlog_load_i,
    input wire logic [127:0] hlog_i,
    // Power budget data source
    output logic [7:0] pb_select_o,
    input wire pcxcfg_pkg::pcxcfg_word_t pb_data_i,
    input wire pcxcfg_pkg::pcxcfg_word_t pb_cap_i,
    // Arbitration table read port for the scheduler
    input wire logic [3:0] arb_idx_i,
    output pcxcfg_pkg::pcxcfg_word_t arb_word_o
);
    logic [15:0] maker_q;
    logic [15:0] part_q;
    pcxcfg_pkg::pcxcfg_word_t ue_sts_q, ue_msk_q, ue_sev_q, ce_sts_q, ce_msk_q, aer_ctl_q;
    logic [127:0] hlog_q;
    logic [15:0] pvc_ctl_q;
    pcxcfg_pkg::pcxcfg_word_t vc0_ctl_q;
    logic [7:0] pb_sel_q;
    pcxcfg_pkg::pcxcfg_word_t arb_q [`PCXCFG_ARB_WORDS];
    pcxcfg_pkg::pcxcfg_word_t rdata_d;
    pcxcfg_pkg::pcxcfg_word_t bemask;
    logic wr;

    function automatic logic hit(input pcxcfg_pkg::pcxcfg_addr_t a, input pcxcfg_pkg::pcxcfg_addr_t off);
        hit = (a[11:2] == off[11:2]);
    endfunction

    function automatic logic in_arb(input pcxcfg_pkg::pcxcfg_addr_t a);
        in_arb = (a[11:2] >= `PCXCFG_OFF_ARB_LO >> 2) && (a[11:2] <= `PCXCFG_OFF_ARB_HI >> 2);
    endfunction

    assign wr = ce_i && cfg_wr_i;
    assign bemask = {{8{cfg_be_i[3]}}, {8{cfg_be_i[2]}}, {8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};

    // Identifiers never take configuration writes; only the override path loads them.
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            maker_q <= MAKER_ID_DEFAULT;
            part_q <= PART_ID_DEFAULT;
        end
        else if (ce_i && id_load_i)
        begin
            maker_q <= id_maker_i;
            part_q <= id_part_i;
        end
    end

    // Status bits are write-one-to-clear and a new event wins over a clear.
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            ue_sts_q <= 32'h0;
            ce_sts_q <= 32'h0;
        end
        else if (ce_i)
        begin
            ue_sts_q <= (ue_sts_q & ~((wr && hit(cfg_addr_i, `PCXCFG_OFF_UE_STS)) ? cfg_wdata_i & bemask : 32'h0))
                | ue_event_i;
            ce_sts_q <= (ce_sts_q & ~((wr && hit(cfg_addr_i, `PCXCFG_OFF_CE_STS)) ? cfg_wdata_i & bemask : 32'h0))
                | ce_event_i;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            ue_msk_q <= 32'h0;
            ue_sev_q <= `PCXCFG_UE_SEV_RST;
            ce_msk_q <= 32'h0;
            aer_ctl_q <= 32'h0;
            pvc_ctl_q <= 16'h0;
            vc0_ctl_q <= `PCXCFG_VC0_CTL_RST;
            pb_sel_q <= 8'h0;
        end
        else if (wr)
        begin
            if (hit(cfg_addr_i, `PCXCFG_OFF_UE_MSK))
                ue_msk_q <= (ue_msk_q & ~bemask) | (cfg_wdata_i & bemask & `PCXCFG_UE_MSK_BITS);
            else if (hit(cfg_addr_i, `PCXCFG_OFF_UE_SEV))
                ue_sev_q <= (ue_sev_q & ~bemask) | (cfg_wdata_i & bemask & `PCXCFG_UE_MSK_BITS);
            else if (hit(cfg_addr_i, `PCXCFG_OFF_CE_MSK))
                ce_msk_q <= (ce_msk_q & ~bemask) | (cfg_wdata_i & bemask & `PCXCFG_CE_MSK_BITS);
            else if (hit(cfg_addr_i, `PCXCFG_OFF_AER_CTL))
                aer_ctl_q <= (aer_ctl_q & ~bemask) | (cfg_wdata_i & bemask & `PCXCFG_AER_CTL_BITS);
            else if (hit(cfg_addr_i, `PCXCFG_OFF_PVC_CTLSTS))
                pvc_ctl_q <= (pvc_ctl_q & ~bemask[15:0]) | (cfg_wdata_i[15:0] & bemask[15:0] & 16'h000F);
            else if (hit(cfg_addr_i, `PCXCFG_OFF_VC0_CTL))
                vc0_ctl_q <= (vc0_ctl_q & ~bemask) | (cfg_wdata_i & bemask & `PCXCFG_VC0_CTL_BITS)
                    | 32'h8000_0001;
            else if (hit(cfg_addr_i, `PCXCFG_OFF_PB_SEL) && cfg_be_i[0])
                pb_sel_q <= cfg_wdata_i[7:0];
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            hlog_q <= 128'h0;
        else if (ce_i && hlog_load_i)
            hlog_q <= hlog_i;
    end

    // Each table word holds eight 4-bit phases.
    genvar gi;
    generate
        for (gi = 0; gi < `PCXCFG_ARB_WORDS; gi++)
        begin : g_arb
            always_ff @(posedge clk_sys_i)
            begin
                if (srst_i)
                    arb_q[gi] <= 32'h0;
                else if (wr && hit(cfg_addr_i, 12'(`PCXCFG_OFF_ARB_LO + 4 * gi)))
                    arb_q[gi] <= (arb_q[gi] & ~bemask) | (cfg_wdata_i & bemask);
            end
        end
    endgenerate

    always_comb
    begin
        rdata_d = 32'h0;
        if (hit(cfg_addr_i, `PCXCFG_OFF_ID))
            rdata_d = {part_q, maker_q};
        else if (hit(cfg_addr_i, `PCXCFG_OFF_AER_HDR))
            rdata_d = `PCXCFG_AER_HDR_VAL;
        else if (hit(cfg_addr_i, `PCXCFG_OFF_UE_STS))
            rdata_d = ue_sts_q;
        else if (hit(cfg_addr_i, `PCXCFG_OFF_UE_MSK))
            rdata_d = ue_msk_q;
        else if (hit(cfg_addr_i, `PCXCFG_OFF_UE_SEV))
            rdata_d = ue_sev_q;
        else if (hit(cfg_addr_i, `PCXCFG_OFF_CE_STS))
            rdata_d = ce_sts_q;
        else if (hit(cfg_addr_i, `PCXCFG_OFF_CE_MSK))
            rdata_d = ce_msk_q;
        else if (hit(cfg_addr_i, `PCXCFG_OFF_AER_CTL))
            rdata_d = aer_ctl_q | 32'h0000_00A0;
        else if (cfg_addr_i[11:2] >= `PCXCFG_OFF_HLOG_LO >> 2 && cfg_addr_i[11:2] <= `PCXCFG_OFF_HLOG_HI >> 2)
            // The concatenation keeps the word index at two bits, so 120h wraps to word one.
            rdata_d = hlog_q[{cfg_addr_i[3:2] - 2'd3, 5'd0} +: 32];
        else if (hit(cfg_addr_i, `PCXCFG_OFF_VC_HDR))
            rdata_d = `PCXCFG_VC_HDR_VAL;
        else if (hit(cfg_addr_i, `PCXCFG_OFF_PVC_CAP1))
            rdata_d = 32'h0;
        else if (hit(cfg_addr_i, `PCXCFG_OFF_PVC_CAP2))
            rdata_d = `PCXCFG_PVC_CAP2_VAL;
        else if (hit(cfg_addr_i, `PCXCFG_OFF_PVC_CTLSTS))
            rdata_d = {16'h0, pvc_ctl_q};
        else if (hit(cfg_addr_i, `PCXCFG_OFF_VC0_CAP))
            rdata_d = `PCXCFG_VC0_CAP_VAL;
        else if (hit(cfg_addr_i, `PCXCFG_OFF_VC0_CTL))
            rdata_d = vc0_ctl_q;
        else if (hit(cfg_addr_i, `PCXCFG_OFF_VC0_STS))
            rdata_d = 32'h0;
        else if (in_arb(cfg_addr_i))
            rdata_d = arb_q[cfg_addr_i[5:2]];
        else if (hit(cfg_addr_i, `PCXCFG_OFF_PB_HDR))
            rdata_d = `PCXCFG_PB_HDR_VAL;
        else if (hit(cfg_addr_i, `PCXCFG_OFF_PB_SEL))
            rdata_d = {24'h0, pb_sel_q};
        else if (hit(cfg_addr_i, `PCXCFG_OFF_PB_DATA))
            rdata_d = pb_data_i;
        else if (hit(cfg_addr_i, `PCXCFG_OFF_PB_CAP))
            rdata_d = {31'h0, pb_cap_i[0]};
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            cfg_rvalid_o <= 1'b0;
            cfg_rdata_o <= 32'h0;
        end
        else if (ce_i)
        begin
            cfg_rvalid_o <= cfg_rd_i;
            if (cfg_rd_i)
                cfg_rdata_o <= rdata_d;
        end
    end

    assign pb_select_o = pb_sel_q;
    assign arb_word_o = arb_q[arb_idx_i];

    AST_ID_READ: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && cfg_rd_i && cfg_addr_i[11:2] == 10'h0 |=> cfg_rvalid_o && cfg_rdata_o == {part_q, maker_q})
        else $error("identifier read mismatch");
    AST_ID_WR_IGNORED: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && cfg_wr_i && !id_load_i |=> $stable(part_q) && $stable(maker_q))
        else $error("identifier changed by config write");
    AST_ID_LOAD: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && id_load_i |=> maker_q == $past(id_maker_i) && part_q == $past(id_part_i))
        else $error("identifier override not taken");
    AST_AER_HDR: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && cfg_rd_i && cfg_addr_i[11:2] == 10'h040 |=> cfg_rdata_o[15:0] == 16'h0001)
        else $error("error capability id wrong");
    AST_ARB_OFFS: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && cfg_rd_i && (cfg_addr_i[11:2] == 10'h052 || cfg_addr_i[11:2] == 10'h054)
        |=> cfg_rdata_o[31:24] == ($past(cfg_addr_i[4]) ? 8'h04 : 8'h03))
        else $error("arbitration table offset wrong");
    AST_ARB_RW: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && cfg_wr_i && cfg_be_i == 4'hF && cfg_addr_i[11:6] == 6'h06
        |=> arb_q[$past(cfg_addr_i[5:2])] == $past(cfg_wdata_i))
        else $error("arbitration table write lost");
    AST_PB_END: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && cfg_rd_i && cfg_addr_i[11:2] == 10'h083 |=> cfg_rdata_o[31:20] == 12'h000 && cfg_rdata_o[15:0] == 16'h0004)
        else $error("power budget header wrong");
    AST_EXT_ABOVE: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && cfg_rd_i && cfg_addr_i[11:2] == 10'h040 |=> cfg_rdata_o[31:20] > 12'h0FF)
        else $error("next capability below extended space");
    AST_RSVD_ZERO: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && cfg_rd_i && cfg_addr_i[11:2] >= 10'h070 && cfg_addr_i[11:2] <= 10'h082 |=> cfg_rdata_o == 32'h0)
        else $error("reserved range not zero");

    // Error status, mask and header log.
    AST_UE_SET_WINS: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && ue_event_i != 32'h0 |=> (ue_sts_q & $past(ue_event_i)) == $past(ue_event_i))
        else $error("uncorrectable event lost");
    AST_CE_SET_WINS: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && ce_event_i != 32'h0 |=> (ce_sts_q & $past(ce_event_i)) == $past(ce_event_i))
        else $error("correctable event lost");
    AST_UE_CLEAR: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && cfg_wr_i && cfg_be_i == 4'hF && cfg_addr_i[11:2] == 10'h041 && ue_event_i == 32'h0
        |=> (ue_sts_q & $past(cfg_wdata_i)) == 32'h0)
        else $error("status bit not cleared");
    AST_UE_MSK_BITS: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && cfg_wr_i && cfg_addr_i[11:2] == 10'h042 |=> (ue_msk_q & ~`PCXCFG_UE_MSK_BITS) == 32'h0)
        else $error("fixed mask bit written");
    AST_HLOG_LO: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && cfg_rd_i && cfg_addr_i[11:2] == 10'h047 |=> cfg_rdata_o == $past(hlog_q[31:0]))
        else $error("header log word zero wrong");
    AST_HLOG_HI: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && cfg_rd_i && cfg_addr_i[11:2] == 10'h04A |=> cfg_rdata_o == $past(hlog_q[127:96]))
        else $error("header log word three wrong");

    // Channel and power budget reads, and the data select write.
    AST_VC_NEXT: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && cfg_rd_i && cfg_addr_i[11:2] == 10'h050 |=> cfg_rdata_o[31:20] > 12'h0FF)
        else $error("channel next capability below extended space");
    AST_ARB_READ: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && cfg_rd_i && cfg_addr_i[11:6] == 6'h06 |=> cfg_rdata_o == $past(arb_q[cfg_addr_i[5:2]]))
        else $error("arbitration table read wrong");
    AST_PB_SEL_WR: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && cfg_wr_i && cfg_be_i[0] && cfg_addr_i[11:2] == 10'h084 |=> pb_select_o == $past(cfg_wdata_i[7:0]))
        else $error("data select write lost");
    AST_PB_DATA: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && cfg_rd_i && cfg_addr_i[11:2] == 10'h085 |=> cfg_rdata_o == $past(pb_data_i))
        else $error("power budget data wrong");
    AST_PB_CAP: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && cfg_rd_i && cfg_addr_i[11:2] == 10'h086 |=> cfg_rdata_o == {31'h0, $past(pb_cap_i[0])})
        else $error("power budget capability wrong");

    // Handshake, enable and reset behaviour.
    AST_RVALID_PULSE: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && !cfg_rd_i |=> !cfg_rvalid_o)
        else $error("read valid without a read");
    AST_RDATA_HOLD: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && !cfg_rd_i |=> $stable(cfg_rdata_o))
        else $error("read data changed without a read");
    AST_CE_FREEZE: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        !ce_i |=> $stable(arb_q[0]) && $stable(pb_sel_q) && $stable(maker_q) && $stable(ue_sts_q)
        && $stable(hlog_q) && $stable(cfg_rvalid_o))
        else $error("state moved while enable low");
    AST_RESET_CLEAN: assert property (@(posedge clk_sys_i)
        srst_i |=> !cfg_rvalid_o && cfg_rdata_o == 32'h0 && pb_select_o == 8'h0)
        else $error("outputs not cleared by reset");
    COV_ID_LOAD: cover property (@(posedge clk_sys_i) ce_i && id_load_i);
    COV_ARB_WR: cover property (@(posedge clk_sys_i) ce_i && cfg_wr_i && in_arb(cfg_addr_i));
    COV_UE_CLR: cover property (@(posedge clk_sys_i) wr && hit(cfg_addr_i, `PCXCFG_OFF_UE_STS) && |ue_sts_q);
    COV_HLOG_RD: cover property (@(posedge clk_sys_i) ce_i && cfg_rd_i && cfg_addr_i[11:2] == 10'h048);
    COV_CE_LOW: cover property (@(posedge clk_sys_i) !ce_i && cfg_wr_i);
endmodule
`default_nettype wire

// *** rtl/pcxcfg_defs.svh ***
`ifndef PCXCFG_DEFS_SVH
`define PCXCFG_DEFS_SVH
`define PCXCFG_OFF_ID 12'h000
`define PCXCFG_OFF_AER_HDR 12'h100
`define PCXCFG_OFF_UE_STS 12'h104
`define PCXCFG_OFF_UE_MSK 12'h108
`define PCXCFG_OFF_UE_SEV 12'h10C
`define PCXCFG_OFF_CE_STS 12'h110
`define PCXCFG_OFF_CE_MSK 12'h114
`define PCXCFG_OFF_AER_CTL 12'h118
`define PCXCFG_OFF_HLOG_LO 12'h11C
`define PCXCFG_OFF_HLOG_HI 12'h128
`define PCXCFG_OFF_VC_HDR 12'h140
`define PCXCFG_OFF_PVC_CAP1 12'h144
`define PCXCFG_OFF_PVC_CAP2 12'h148
`define PCXCFG_OFF_PVC_CTLSTS 12'h14C
`define PCXCFG_OFF_VC0_CAP 12'h150
`define PCXCFG_OFF_VC0_CTL 12'h154
`define PCXCFG_OFF_VC0_STS 12'h158
`define PCXCFG_OFF_ARB_LO 12'h180
`define PCXCFG_OFF_ARB_HI 12'h1BC
`define PCXCFG_OFF_PB_HDR 12'h20C
`define PCXCFG_OFF_PB_SEL 12'h210
`define PCXCFG_OFF_PB_DATA 12'h214
`define PCXCFG_OFF_PB_CAP 12'h218
`define PCXCFG_EXT_BASE 12'h100
`define PCXCFG_ARB_WORDS 16
`define PCXCFG_AER_HDR_VAL 32'h1401_0001
`define PCXCFG_VC_HDR_VAL 32'h20C1_0002
`define PCXCFG_PB_HDR_VAL 32'h0001_0004
`define PCXCFG_PVC_CAP2_VAL 32'h0300_0000
`define PCXCFG_VC0_CAP_VAL 32'h0400_0000
`define PCXCFG_UE_MSK_BITS 32'h003F_F030
`define PCXCFG_CE_MSK_BITS 32'h0000_31C1
`define PCXCFG_AER_CTL_BITS 32'h0000_0140
`define PCXCFG_VC0_CTL_BITS 32'h8F0E_00FF
`define PCXCFG_VC0_CTL_RST 32'h8000_00FF
`define PCXCFG_UE_SEV_RST 32'h0006_2030
`define PCXCFG_ERR_HDR_ID 16'h0001
`endif

// *** rtl/pcxcfg_pkg.sv ***
package pcxcfg_pkg;
    typedef logic [11:0] pcxcfg_addr_t;
    typedef logic [31:0] pcxcfg_word_t;
endpackage

// *** dv/pcxcfg_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module pcxcfg_host_model (
    // Clock and answer
    input wire logic clk_sys_i,
    input wire logic cfg_rvalid_i,
    input wire pcxcfg_pkg::pcxcfg_word_t cfg_rdata_i,
    // Requests
    output logic cfg_rd_o,
    output logic cfg_wr_o,
    output pcxcfg_pkg::pcxcfg_addr_t cfg_addr_o,
    output pcxcfg_pkg::pcxcfg_word_t cfg_wdata_o,
    output logic [3:0] cfg_be_o
);
    initial
    begin
        cfg_rd_o = 1'b0;
        cfg_wr_o = 1'b0;
        cfg_addr_o = 12'hFFF;
        cfg_wdata_o = 32'h0;
        cfg_be_o = 4'h0;
    end
    // Idle address, data and byte-enable lines show the inverse of their last value, so a stale address can never pass for a live one.
    task automatic idle();
        @(negedge clk_sys_i);
        cfg_rd_o = 1'b0;
        cfg_wr_o = 1'b0;
        cfg_addr_o = ~cfg_addr_o;
        cfg_wdata_o = ~cfg_wdata_o;
        cfg_be_o = ~cfg_be_o;
    endtask
    // Leaves the write raised, so a following write goes back to back.
    task automatic wr(input pcxcfg_pkg::pcxcfg_addr_t a, input pcxcfg_pkg::pcxcfg_word_t d, input logic [3:0] b);
        @(negedge clk_sys_i);
        cfg_wr_o = 1'b1;
        cfg_addr_o = a;
        cfg_wdata_o = d;
        cfg_be_o = b;
        @(posedge clk_sys_i);
    endtask
    // The answer is registered on the taking edge itself, so it is sampled at the next falling edge.
    task automatic rd(input pcxcfg_pkg::pcxcfg_addr_t a, output pcxcfg_pkg::pcxcfg_word_t d, output logic ok);
        @(negedge clk_sys_i);
        cfg_rd_o = 1'b1;
        cfg_addr_o = a;
        @(posedge clk_sys_i);
        idle();
        ok = (cfg_rvalid_i === 1'b1);
        d = cfg_rdata_i;
    endtask
endmodule
`default_nettype wire

// *** dv/pcxcfg_regs_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module pcxcfg_regs_tb_top;
    // Arbitrary identifier defaults, unlike the design's own.
    localparam logic [15:0] MAKER_DEF = 16'hA1B2;
    localparam logic [15:0] PART_DEF = 16'hC3D4;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic ce_i = 1'b1;
    logic cfg_rd, cfg_wr, cfg_rvalid, id_load;
    logic [3:0] cfg_be;
    logic [3:0] arb_idx = 4'h0;
    logic [7:0] pb_select;
    logic [15:0] id_maker = 16'h0;
    logic [15:0] id_part = 16'h0;
    pcxcfg_pkg::pcxcfg_addr_t cfg_addr;
    pcxcfg_pkg::pcxcfg_word_t cfg_wdata, cfg_rdata, arb_word;
    pcxcfg_pkg::pcxcfg_word_t pb_data = 32'h0;
    logic [31:0] ue_event = 32'h0;
    logic hlog_load = 1'b0;
    logic [127:0] hlog = 128'h0;
    int err_count = 0;
    int checked = 0;
    initial id_load = 1'b0;
    initial
    begin
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    pcxcfg_regs #(.MAKER_ID_DEFAULT(MAKER_DEF), .PART_ID_DEFAULT(PART_DEF)) dut (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(ce_i), .cfg_rd_i(cfg_rd), .cfg_wr_i(cfg_wr),
        .cfg_addr_i(cfg_addr), .cfg_wdata_i(cfg_wdata), .cfg_be_i(cfg_be), .cfg_rvalid_o(cfg_rvalid),
        .cfg_rdata_o(cfg_rdata), .id_load_i(id_load), .id_maker_i(id_maker), .id_part_i(id_part),
        .ue_event_i(ue_event), .ce_event_i(32'h0), .hlog_load_i(hlog_load), .hlog_i(hlog),
        .pb_select_o(pb_select), .pb_data_i(pb_data), .pb_cap_i(32'h0), .arb_idx_i(arb_idx),
        .arb_word_o(arb_word));
    pcxcfg_host_model host (
        .clk_sys_i(clk_sys_i), .cfg_rvalid_i(cfg_rvalid), .cfg_rdata_i(cfg_rdata), .cfg_rd_o(cfg_rd),
        .cfg_wr_o(cfg_wr), .cfg_addr_o(cfg_addr), .cfg_wdata_o(cfg_wdata), .cfg_be_o(cfg_be));
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d.", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input pcxcfg_pkg::pcxcfg_addr_t a, input logic [31:0] mask, input logic [31:0] exp);
        pcxcfg_pkg::pcxcfg_word_t d;
        logic ok;
        host.rd(a, d, ok);
        if (!ok)
        begin
            err_count++;
            report_and_stop();
        end
        check(d & mask, exp);
    endtask
    task automatic t_ident();
        rchk(12'h000, 32'hFFFF_FFFF, {PART_DEF, MAKER_DEF});
        host.wr(12'h000, 32'h0F0F_F0F0, 4'hF);
        host.idle();
        rchk(12'h000, 32'hFFFF_FFFF, {PART_DEF, MAKER_DEF});
        $display("Identifier test done.");
    endtask
    task automatic t_idload();
        @(negedge clk_sys_i);
        id_load = 1'b1;
        id_maker = 16'h3C4D;
        id_part = 16'h5E6F;
        @(negedge clk_sys_i);
        id_load = 1'b0;
        host.wr(12'h000, 32'h0, 4'hF);
        host.idle();
        rchk(12'h000, 32'hFFFF_FFFF, 32'h5E6F_3C4D);
        $display("Identifier load test done.");
    endtask
    task automatic t_headers();
        host.wr(12'h100, 32'h0, 4'hF);
        host.idle();
        rchk(12'h100, 32'hFFFF_FFFF, {12'h140, 4'h1, 16'h0001});
        rchk(12'h140, 32'hFFFF_FFFF, {12'h20C, 4'h1, 16'h0002});
        rchk(12'h148, 32'hFF00_0000, 32'h0300_0000);
        rchk(12'h150, 32'hFF00_0000, 32'h0400_0000);
        rchk(12'h20C, 32'hFFFF_FFFF, {12'h000, 4'h1, 16'h0004});
        $display("Capability header test done.");
    endtask
    task automatic t_arb();
        host.wr(12'h180, 32'h1122_3344, 4'hF);
        host.wr(12'h1BC, 32'hAAAA_AAAA, 4'hF);
        host.wr(12'h1BC, 32'h5566_7788, 4'h5);
        host.idle();
        rchk(12'h180, 32'hFFFF_FFFF, 32'h1122_3344);
        rchk(12'h1BC, 32'hFFFF_FFFF, 32'hAA66_AA88);
        arb_idx = 4'hF;
        @(negedge clk_sys_i);
        check(arb_word, 32'hAA66_AA88);
        $display("Arbitration table test done.");
    endtask
    task automatic t_reserved();
        logic [11:0] adr [8] = '{12'h12C, 12'h13C, 12'h15C, 12'h17C, 12'h1C0, 12'h1FC, 12'h200, 12'h208};
        foreach (adr[i])
        begin
            host.wr(adr[i], 32'hFFFF_FFFF, 4'hF);
            host.idle();
            rchk(adr[i], 32'hFFFF_FFFF, 32'h0);
        end
        $display("Reserved range test done.");
    endtask
    task automatic t_power();
        host.wr(12'h210, 32'h0000_00A5, 4'h1);
        host.idle();
        rchk(12'h210, 32'h0000_00FF, 32'h0000_00A5);
        check({24'h0, pb_select}, 32'h0000_00A5);
        pb_data = 32'hCAFE_0123;
        rchk(12'h214, 32'hFFFF_FFFF, 32'hCAFE_0123);
        $display("Power budget test done.");
    endtask
    task automatic t_errlog();
        @(negedge clk_sys_i);
        ue_event = 32'h0000_0010;
        hlog = {32'h4444_4444, 32'h3333_3333, 32'h2222_2222, 32'h1111_1111};
        hlog_load = 1'b1;
        @(negedge clk_sys_i);
        ue_event = 32'h0;
        hlog_load = 1'b0;
        rchk(12'h104, 32'hFFFF_FFFF, 32'h0000_0010);
        host.wr(12'h104, 32'h0000_0010, 4'hF);
        host.idle();
        rchk(12'h104, 32'hFFFF_FFFF, 32'h0);
        rchk(12'h11C, 32'hFFFF_FFFF, 32'h1111_1111);
        rchk(12'h120, 32'hFFFF_FFFF, 32'h2222_2222);
        rchk(12'h128, 32'hFFFF_FFFF, 32'h4444_4444);
        $display("Error status and log test done.");
    endtask
    task automatic t_freeze_reset();
        @(negedge clk_sys_i);
        ce_i = 1'b0;
        host.wr(12'h180, 32'hDEAD_BEEF, 4'hF);
        host.idle();
        ce_i = 1'b1;
        rchk(12'h180, 32'hFFFF_FFFF, 32'h1122_3344);
        @(negedge clk_sys_i);
        srst_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        srst_i = 1'b0;
        rchk(12'h180, 32'hFFFF_FFFF, 32'h0);
        rchk(12'h000, 32'hFFFF_FFFF, {PART_DEF, MAKER_DEF});
        check({24'h0, pb_select}, 32'h0);
        $display("Enable and reset test done.");
    endtask
    initial
    begin
        repeat (12) @(negedge clk_sys_i);
        srst_i = 1'b0;
        t_ident();
        t_idload();
        t_headers();
        t_arb();
        t_reserved();
        t_power();
        t_errlog();
        t_freeze_reset();
        report_and_stop();
    end
endmodule
`default_nettype wire
